// File: design/tyai_consts.svh
// Register offsets, field positions, reset values and counts for the yellow alarm inserter.
`ifndef TYAI_CONSTS_SVH
`define TYAI_CONSTS_SVH

`define TYAI_AGC_OFFSET 12'h108
`define TYAI_FMT_OFFSET 12'h10c
`define TYAI_STAT_OFFSET 12'h110

`define TYAI_AGC_RESET 8'h00
`define TYAI_FMT_RESET 2'h0

`define TYAI_YSEL_LSB 4
`define TYAI_YSEL_MSB 5

`define TYAI_STAT_ACTIVE_BIT 0
`define TYAI_STAT_LEVEL_BIT 1
`define TYAI_STAT_COUNT_LSB 8
`define TYAI_STAT_COUNT_MSB 15

`define TYAI_DS0_ALARM_BIT 6
`define TYAI_DM_ALARM_BIT 2
`define TYAI_DM_ALARM_SLOT 5'h17
`define TYAI_SF_ALARM_FRAME 5'h0c

`define TYAI_PATTERN_LEN 5'h10
`define TYAI_PATTERN_ONES 5'h08
`define TYAI_BURST_PATTERNS 8'hff

`endif

// File: design/tyai_pkg.sv
// Types shared by the yellow alarm inserter modules.
package tyai_pkg;

  typedef enum logic [1:0] {
    TYAI_FMT_SF = 2'h0,
    TYAI_FMT_ESF = 2'h1,
    TYAI_FMT_N = 2'h2,
    TYAI_FMT_DM = 2'h3
  } tyai_format_type;

  typedef enum logic [0:0] {
    TYAI_ESF_IDLE = 1'h0,
    TYAI_ESF_RUN = 1'h1
  } tyai_esf_state_type;

endpackage

// File: design/tyai_link_if.sv
// Signals between the framer path and the data link alarm generator.
`timescale 1ns/100ps
interface tyai_link_if;
  logic dl_strobe;
  logic esf_mode;
  logic [1:0] sel;
  logic active;
  logic level_burst;
  logic pattern_bit;
  logic [7:0] pattern_count;

  modport framer_side (
    output dl_strobe,
    output esf_mode,
    output sel,
    input active,
    input level_burst,
    input pattern_bit,
    input pattern_count
  );

  modport esf_side (
    input dl_strobe,
    input esf_mode,
    input sel,
    output active,
    output level_burst,
    output pattern_bit,
    output pattern_count
  );
endinterface

// File: design/tyai_esf_alarm.sv
// Data link alarm pattern generator with burst counter.
`timescale 1ns/100ps
`include "tyai_consts.svh"
module tyai_esf_alarm
  import tyai_pkg::*;
#(
  parameter logic [7:0] burst_patterns = `TYAI_BURST_PATTERNS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  tyai_link_if.esf_side link
);

  tyai_esf_state_type state;
  logic sel0_last;
  logic [4:0] bit_idx;
  logic [7:0] count;
  logic level;
  logic pulse;
  logic pattern_end;
  logic [7:0] count_inc;
  logic stop_now;

  // A rising select bit 0 in a pulse-driven setting starts or restarts a counted burst.
  assign pulse = link.sel[0] && !sel0_last;
  assign pattern_end = (state == TYAI_ESF_RUN) && link.dl_strobe && (bit_idx == `TYAI_PATTERN_LEN - 5'h01);
  assign count_inc = (count == 8'hff) ? count : count + 8'h01;
  // Bursts end when a whole pattern has gone out, except that leaving ESF format stops the burst at once, mid-pattern.
  assign stop_now = level ? !link.sel[1] : ((count_inc >= burst_patterns) && !link.sel[0]);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel0_last <= 1'b0;
    end else begin
      sel0_last <= link.sel[0];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= TYAI_ESF_IDLE;
      count <= 8'h00;
      level <= 1'b0;
    end else begin
      case (state)
        TYAI_ESF_IDLE: begin
          // Select zero starts nothing, so no alarm leaves the link.
          if (link.esf_mode && pulse) begin
            state <= TYAI_ESF_RUN;
            count <= 8'h00;
            level <= 1'b0;
          end else if (link.esf_mode && link.sel == 2'b10) begin
            state <= TYAI_ESF_RUN;
            count <= 8'h00;
            level <= 1'b1;
          end
        end
        TYAI_ESF_RUN: begin
          if (!link.esf_mode) begin
            state <= TYAI_ESF_IDLE;
          end else if (pulse) begin
            count <= 8'h00;
            level <= 1'b0;
          end else if (pattern_end) begin
            count <= count_inc;
            if (stop_now) begin
              state <= TYAI_ESF_IDLE;
            end
          end
        end
        default: begin
          state <= TYAI_ESF_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_idx <= 5'h00;
    end else if (state != TYAI_ESF_RUN) begin
      bit_idx <= 5'h00;
    end else if (link.dl_strobe) begin
      bit_idx <= (bit_idx == `TYAI_PATTERN_LEN - 5'h01) ? 5'h00 : bit_idx + 5'h01;
    end
  end

  assign link.active = (state == TYAI_ESF_RUN);
  assign link.level_burst = level;
  assign link.pattern_bit = (bit_idx < `TYAI_PATTERN_ONES);
  assign link.pattern_count = count;

endmodule

// File: design/tyai_yellow_alarm.sv
// Transmit yellow alarm inserter with AHB-Lite register slave.
// What this block does
// - N format: nonzero select zeroes DS0 second MSB.
// - Multiplex format: nonzero select clears slot 23 bit.
// - Select zero inserts no alarm, except that an ESF burst already running goes on: a counted one to its count, a level one to its pattern end.
// - Superframe, select 01/11: zero DS0 second MSB.
// - Superframe, select 10: frame 12 alignment bit one.
// - Extended superframe: eight ones, eight zeros on link.
// - Short bit 0 pulse sends exactly 255 patterns.
// - Long bit 0 pulse: send until bit low.
// - New bit 0 pulse restarts the 255 count.
// - Select 10: send while bit 1 high.
`timescale 1ns/100ps
`include "tyai_consts.svh"
module tyai_yellow_alarm
  import tyai_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic in_valid,
  input wire logic in_framing_bit,
  input wire logic [4:0] in_frame,
  input wire logic [4:0] in_slot,
  input wire logic [7:0] in_data,
  output logic out_valid,
  output logic out_framing_bit,
  output logic [4:0] out_frame,
  output logic [4:0] out_slot,
  output logic [7:0] out_data,
  output logic yellow_active
);

  tyai_link_if link ();

  logic [7:0] alarm_generation_control;
  tyai_format_type framing_format_control;
  logic [7:0] next_alarm_generation_control;
  tyai_format_type next_framing_format_control;
  logic wr_pending;
  logic [11:0] wr_addr;
  logic take;
  logic [31:0] next_hrdata;
  logic [31:0] status_word;
  logic [1:0] sel;
  logic [7:0] next_data;
  logic ds0_zero;
  logic dm_zero;

  // The slave never stalls; every transfer completes with OKAY in one data phase cycle.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = hsel && hready && htrans[1] && (hsize == 3'b010);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pending <= 1'b0;
      wr_addr <= 12'h000;
    end else if (hready) begin
      wr_pending <= take && hwrite;
      wr_addr <= haddr[11:0];
    end
  end

  always_comb begin
    next_alarm_generation_control = alarm_generation_control;
    next_framing_format_control = framing_format_control;
    if (wr_pending && wr_addr == `TYAI_AGC_OFFSET) begin
      next_alarm_generation_control = hwdata[7:0];
    end
    if (wr_pending && wr_addr == `TYAI_FMT_OFFSET) begin
      next_framing_format_control = tyai_format_type'(hwdata[1:0]);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_generation_control <= `TYAI_AGC_RESET;
      framing_format_control <= tyai_format_type'(`TYAI_FMT_RESET);
    end else begin
      alarm_generation_control <= next_alarm_generation_control;
      framing_format_control <= next_framing_format_control;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`TYAI_STAT_ACTIVE_BIT] = link.active;
    status_word[`TYAI_STAT_LEVEL_BIT] = link.active && link.level_burst;
    status_word[`TYAI_STAT_COUNT_MSB:`TYAI_STAT_COUNT_LSB] = link.pattern_count;
  end

  // Reads use the next register values so a read right behind a write sees the new data.
  always_comb begin
    next_hrdata = 32'h0000_0000;
    case (haddr[11:0])
      `TYAI_AGC_OFFSET: begin
        next_hrdata = {24'h000000, next_alarm_generation_control};
      end
      `TYAI_FMT_OFFSET: begin
        next_hrdata = {30'h0, next_framing_format_control};
      end
      `TYAI_STAT_OFFSET: begin
        next_hrdata = status_word;
      end
      default: begin
        next_hrdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      hrdata <= (take && !hwrite) ? next_hrdata : 32'h0000_0000;
    end
  end

  assign sel = alarm_generation_control[`TYAI_YSEL_MSB:`TYAI_YSEL_LSB];

  // Only odd frames carry data link bits in the extended superframe.
  assign link.dl_strobe = in_valid && in_framing_bit && in_frame[0] && (framing_format_control == TYAI_FMT_ESF);
  assign link.esf_mode = (framing_format_control == TYAI_FMT_ESF);
  assign link.sel = sel;

  tyai_esf_alarm #(
    .burst_patterns(`TYAI_BURST_PATTERNS)
  ) u_esf_alarm (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .link(link.esf_side)
  );

  assign ds0_zero = (sel != 2'b00) && ((framing_format_control == TYAI_FMT_N) ||
                    ((framing_format_control == TYAI_FMT_SF) && (sel != 2'b10)));
  assign dm_zero = (sel != 2'b00) && (framing_format_control == TYAI_FMT_DM) &&
                   (in_slot == `TYAI_DM_ALARM_SLOT);

  always_comb begin
    next_data = in_data;
    if (!in_framing_bit) begin
      if (ds0_zero) begin
        next_data[`TYAI_DS0_ALARM_BIT] = 1'b0;
      end
      if (dm_zero) begin
        next_data[`TYAI_DM_ALARM_BIT] = 1'b0;
      end
    end else begin
      if ((framing_format_control == TYAI_FMT_SF) && (sel == 2'b10) && (in_frame == `TYAI_SF_ALARM_FRAME)) begin
        next_data[0] = 1'b1;
      end
      if (link.dl_strobe && link.active) begin
        next_data[0] = link.pattern_bit;
      end
    end
  end

  // One register stage on the stream; there is no back-pressure, the framer keeps its own pace.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_framing_bit <= 1'b0;
      out_frame <= 5'h00;
      out_slot <= 5'h00;
      out_data <= 8'h00;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_framing_bit <= in_framing_bit;
        out_frame <= in_frame;
        out_slot <= in_slot;
        out_data <= next_data;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      yellow_active <= 1'b0;
    end else begin
      yellow_active <= link.active || ds0_zero || ((sel != 2'b00) && (framing_format_control == TYAI_FMT_DM)) ||
                       ((framing_format_control == TYAI_FMT_SF) && (sel == 2'b10));
    end
  end

endmodule

// File: verification/tyai_yellow_alarm_properties.sv
// Checker for the stream and bus ports of the yellow alarm inserter.
`timescale 1ns/100ps
module tyai_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic in_framing_bit,
  input wire logic [4:0] in_frame,
  input wire logic [4:0] in_slot,
  input wire logic [7:0] in_data,
  input wire logic out_valid,
  input wire logic out_framing_bit,
  input wire logic [4:0] out_frame,
  input wire logic [4:0] out_slot,
  input wire logic [7:0] out_data,
  input wire logic hreadyout,
  input wire logic hresp
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence octet_in;
    in_valid && !in_framing_bit;
  endsequence
  sequence framing_in;
    in_valid && in_framing_bit;
  endsequence
  valid_follow_a: assert property (out_valid == $past(in_valid)) else $error("output valid not one cycle late");
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus slave not ready or not okay");
  label_copy_a: assert property (in_valid |=> out_frame == $past(in_frame) && out_slot == $past(in_slot)
    && out_framing_bit == $past(in_framing_bit)) else $error("item labels not copied");
  octet_keep_a: assert property (octet_in |=> (out_data & 8'hbb) == ($past(in_data) & 8'hbb))
    else $error("octet bit changed outside alarm bits");
  clear_only_a: assert property (octet_in |=> (out_data & ~$past(in_data)) == 8'h00)
    else $error("octet bit set by alarm");
  slot_bit_a: assert property (octet_in ##0 in_slot != 5'h17 |=> out_data[2] == $past(in_data[2]))
    else $error("third bit cleared outside slot 23");
  framing_keep_a: assert property (framing_in |=> out_data[7:1] == $past(in_data[7:1]))
    else $error("framing item upper bits changed");
  hold_out_a: assert property (!in_valid |=> $stable(out_data) && $stable(out_slot) && !out_valid)
    else $error("outputs moved without input");
endmodule

bind tyai_yellow_alarm tyai_checker chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .in_valid(in_valid),
  .in_framing_bit(in_framing_bit), .in_frame(in_frame), .in_slot(in_slot), .in_data(in_data),
  .out_valid(out_valid), .out_framing_bit(out_framing_bit), .out_frame(out_frame), .out_slot(out_slot),
  .out_data(out_data), .hreadyout(hreadyout), .hresp(hresp));

// File: verification/tyai_line_receiver.sv
// Remote receiver model that collects data link bits from the outgoing stream.
`timescale 1ns/100ps
module tyai_line_receiver (
  input wire logic sys_clk,
  input wire logic out_valid,
  input wire logic out_framing_bit,
  input wire logic [4:0] out_frame,
  input wire logic [7:0] out_data,
  output int ones,
  output int misplaced
);
  int pos = 0;
  int ones_seen = 0;
  int bad_seen = 0;
  // One driver per output: the counters live here and the ports only show them.
  assign ones = ones_seen;
  assign misplaced = bad_seen;
  // Position only stays aligned because the bench sends whole patterns per run.
  always @(posedge sys_clk) begin
    if (out_valid && out_framing_bit && out_frame[0]) begin
      if (out_data[0] === 1'b1) begin
        ones_seen++;
        if (pos % 16 >= 8) bad_seen++;
      end
      pos++;
    end
  end
endmodule

// File: verification/tyai_yellow_alarm_tb.sv
// Self-checking bench for the yellow alarm inserter.
`timescale 1ns/100ps
module tyai_yellow_alarm_tb;
  logic sys_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, in_valid = 0, in_framing_bit = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [4:0] in_frame = 0, in_slot = 0, out_frame, out_slot;
  logic [7:0] in_data = 0, out_data;
  logic hreadyout, hresp, out_valid, out_framing_bit, yellow_active;
  int err_total = 0, tests_run = 0, ones, misplaced, base;
  tyai_yellow_alarm dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .in_valid(in_valid), .in_framing_bit(in_framing_bit), .in_frame(in_frame), .in_slot(in_slot),
    .in_data(in_data), .out_valid(out_valid), .out_framing_bit(out_framing_bit), .out_frame(out_frame),
    .out_slot(out_slot), .out_data(out_data), .yellow_active(yellow_active));
  tyai_line_receiver far (.sys_clk(sys_clk), .out_valid(out_valid), .out_framing_bit(out_framing_bit),
    .out_frame(out_frame), .out_data(out_data), .ones(ones), .misplaced(misplaced));
  initial forever #4 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {20'h0, a};
    do @(posedge sys_clk); while (!hreadyout);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (!hreadyout);
    rd = hrdata;
  endtask
  task automatic item(input logic fb, input logic [4:0] fr, input logic [4:0] sl, input logic [7:0] d);
    @(posedge sys_clk);
    in_valid <= 1;
    in_framing_bit <= fb;
    in_frame <= fr;
    in_slot <= sl;
    in_data <= d;
  endtask
  // Reference: which bit each format and select value may touch.
  function automatic logic [7:0] model(int f, int s, logic fb, int fr, int sl, logic [7:0] d);
    if (fb) return (f == 0 && s == 2 && fr == 12) ? (d | 8'h01) : d;
    if ((f == 0 && s % 2 == 1) || (f == 2 && s != 0)) d[6] = 1'b0;
    if (f == 3 && s != 0 && sl == 23) d[2] = 1'b0;
    return d;
  endfunction
  task automatic one(input int f, input int s, input logic fb, input int fr, input int sl);
    logic [7:0] d;
    d = 8'($urandom);
    item(fb, 5'(fr), 5'(sl), d);
    @(posedge sys_clk);
    in_valid <= 0;
    #1 chk(out_data, model(f, s, fb, fr, sl, d));
  endtask
  // Data link items carry a zero, so every one seen by the receiver is alarm.
  task automatic dl(input int n);
    for (int i = 0; i < n * 16; i++) item(1'b1, 5'(1 + 2 * (i % 12)), 5'h0, 8'($urandom) & 8'hfe);
    @(posedge sys_clk);
    in_valid <= 0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    conclude();
  end
  initial begin
    void'($urandom(45283));
    repeat (8) @(posedge sys_clk);
    sys_rst <= 0;
    bus(0, 12'h108, 0);
    chk(rd, 32'h0);
    bus(0, 12'h10c, 0);
    chk(rd, 32'h0);
    bus(0, 12'h200, 0);
    chk(rd, 32'h0);
    bus(1, 12'h108, 32'ha5);
    bus(0, 12'h108, 0);
    chk(rd, 32'ha5);
    $display("registers done");
    for (int f = 0; f < 4; f++) begin
      bus(1, 12'h10c, 32'(f));
      for (int s = 0; s < 4; s++) begin
        bus(1, 12'h108, 32'({2'(s), 4'($urandom)}));
        one(f, s, 1'b0, 3, 23);
        one(f, s, 1'b0, 3, $urandom % 23);
        one(f, s, 1'b1, 12, 0);
      end
    end
    chk(yellow_active, 1'b1);
    bus(1, 12'h108, 0);
    repeat (2) @(posedge sys_clk);
    chk(yellow_active, 1'b0);
    bus(1, 12'h10c, 1);
    $display("formats done");
    base = ones;
    bus(1, 12'h108, 32'h10);
    bus(1, 12'h108, 0);
    dl(260);
    chk(ones - base, 255 * 8);
    bus(0, 12'h110, 0);
    chk(rd, 32'h0000_ff00);
    base = ones;
    bus(1, 12'h108, 32'h10);
    bus(1, 12'h108, 0);
    dl(100);
    bus(1, 12'h108, 32'h10);
    bus(1, 12'h108, 0);
    dl(260);
    chk(ones - base, 355 * 8);
    base = ones;
    bus(1, 12'h108, 32'h30);
    dl(300);
    bus(1, 12'h108, 0);
    dl(4);
    chk(ones - base, 301 * 8);
    base = ones;
    bus(1, 12'h108, 32'h20);
    bus(0, 12'h110, 0);
    chk(rd, 32'h0000_0003);
    dl(20);
    bus(1, 12'h108, 0);
    dl(4);
    chk(ones - base, 21 * 8);
    chk(misplaced, 0);
    $display("bursts done");
    conclude();
  end
endmodule
